// [hw/epc_pkg.sv]
// Shared constants of the encoder pulse counter
package epc_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register word indices on the 4-bit register port
	localparam logic [3:0] EPC_A_KIND      = 4'h0;
	localparam logic [3:0] EPC_A_PPR       = 4'h1;
	localparam logic [3:0] EPC_A_INVERT    = 4'h2;
	localparam logic [3:0] EPC_A_TAG       = 4'h3;
	localparam logic [3:0] EPC_A_ENABLE    = 4'h4;
	localparam logic [3:0] EPC_A_DIRSEL    = 4'h5;
	localparam logic [3:0] EPC_A_WRAP      = 4'h6;
	localparam logic [3:0] EPC_A_LOAD      = 4'h7;
	localparam logic [3:0] EPC_A_PRE_LO    = 4'h8;
	localparam logic [3:0] EPC_A_PRE_HI    = 4'h9;
	localparam logic [3:0] EPC_A_VAL_LO    = 4'ha;
	localparam logic [3:0] EPC_A_VAL_HI    = 4'hb;
	localparam logic [3:0] EPC_A_DIVISOR   = 4'hc;
	localparam logic [3:0] EPC_A_STATUS    = 4'hd;

	////////////////////////////////////////////////////////////////////////////////
	// Field encodings
	localparam logic [1:0] EPC_KIND_QUAD   = 2'h0;
	localparam logic [1:0] EPC_KIND_PDIR   = 2'h1;
	localparam logic [1:0] EPC_KIND_SINGLE = 2'h2;
	localparam logic [1:0] EPC_DIR_AUTO    = 2'h0;
	localparam logic [1:0] EPC_DIR_UP      = 2'h1;
	localparam logic [1:0] EPC_DIR_DOWN    = 2'h2;
	localparam int         EPC_HALF_LO     = 0;
	localparam int         EPC_HALF_HI     = 16;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values and limits
	localparam logic [1:0]  EPC_RST_KIND    = EPC_KIND_QUAD;
	localparam logic [15:0] EPC_RST_PPR     = 16'h0400;
	localparam logic [15:0] EPC_RST_TAG     = 16'h0000;
	localparam logic [1:0]  EPC_RST_DIRSEL  = EPC_DIR_AUTO;
	localparam logic [15:0] EPC_RST_PRESET  = 16'h0000;
	localparam logic [15:0] EPC_RST_DIVISOR = 16'h0001;
	localparam logic [31:0] EPC_CNT_MAX     = 32'hffff_ffff;
	localparam logic [31:0] EPC_CNT_MIN     = 32'h0000_0000;
	localparam logic [5:0]  EPC_DIV_STEPS   = 6'h20;

	// Divider sequencer
	typedef enum logic [1:0] {EPC_DIV_IDLE, EPC_DIV_RUN, EPC_DIV_DONE} epc_div_st_t;

endpackage

// [hw/epc_top.sv]
// Functional notes
// - Quadrature mode takes channels A and B and derives both speed and direction.
// - Pulse-and-direction mode counts pulses on A and takes direction from the level of B.
// - Single-pulse mode uses only A and derives no direction from the encoder.
// - A pulses-per-revolution setting, default 1024, is held for speed scaling.
// - Direction invert reverses the decoded direction in quadrature and pulse-dir modes only.
// - The result goes to a destination identified by a tag, default zero meaning not set.
// - With counting enabled each pulse moves the count by one; disabled, the default, it holds.
// - Direction select up increments and down decrements on each pulse.
// - Direction select auto, the default, follows the decoded direction.
// - With rollover on the count wraps max to min going up and min to max going down.
// - With rollover off, the default, the count saturates at max or min.
// - While preset load is on the count takes the 32-bit preset from its two halves.
// - The count is readable as two read-only 16-bit halves.
// - The count is unsigned with a maximum of 4,294,967,295.
// - The count is divided by a divisor, default 1, before going to the destination.
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/10ps
module epc_top (
	input  wire logic        core_clk,   // 125 MHz system clock
	input  wire logic        rst_b,      // Async reset, active low
	input  wire logic [3:0]  reg_addr,   // Register word index
	input  wire logic [15:0] reg_wdata,  // Write data
	input  wire logic        reg_wr,     // Write strobe
	input  wire logic        reg_rd,     // Read strobe
	output logic      [15:0] reg_rdata,  // Read data, cycle after strobe
	input  wire logic        enc_a,      // Encoder channel A
	input  wire logic        enc_b,      // Encoder channel B
	output logic      [15:0] ppr_out,    // Pulses per revolution
	output logic             dir_fwd,    // Decoded direction, 1 forward
	output logic      [15:0] dest_tag,   // Destination parameter tag
	output logic      [31:0] dest_value, // Divided count
	output logic             dest_wr     // Destination write pulse
);
	import epc_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Configuration registers
	logic [1:0]  kind_q;
	logic [15:0] ppr_q;
	logic        invert_q;
	logic [15:0] tag_q;
	logic        enable_q;
	logic [1:0]  dirsel_q;
	logic        wrap_q;
	logic        load_q;
	logic [15:0] pre_lo_q;
	logic [15:0] pre_hi_q;
	logic [15:0] divisor_q;

	// Write decode of one register index
	function automatic logic wr_hit(input logic [3:0] a, input logic [3:0] idx, input logic w);
		return w && (a == idx);
	endfunction

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			kind_q    <= EPC_RST_KIND;
			ppr_q     <= EPC_RST_PPR;
			invert_q  <= 1'b0;
			tag_q     <= EPC_RST_TAG;
			enable_q  <= 1'b0;
			dirsel_q  <= EPC_RST_DIRSEL;
			wrap_q    <= 1'b0;
			load_q    <= 1'b0;
			pre_lo_q  <= EPC_RST_PRESET;
			pre_hi_q  <= EPC_RST_PRESET;
			divisor_q <= EPC_RST_DIVISOR;
		end else begin
			if (wr_hit(reg_addr, EPC_A_KIND, reg_wr)) kind_q <= reg_wdata[1:0];
			if (wr_hit(reg_addr, EPC_A_PPR, reg_wr)) ppr_q <= reg_wdata;
			if (wr_hit(reg_addr, EPC_A_INVERT, reg_wr)) invert_q <= reg_wdata[0];
			if (wr_hit(reg_addr, EPC_A_TAG, reg_wr)) tag_q <= reg_wdata;
			if (wr_hit(reg_addr, EPC_A_ENABLE, reg_wr)) enable_q <= reg_wdata[0];
			if (wr_hit(reg_addr, EPC_A_DIRSEL, reg_wr)) dirsel_q <= reg_wdata[1:0];
			if (wr_hit(reg_addr, EPC_A_WRAP, reg_wr)) wrap_q <= reg_wdata[0];
			if (wr_hit(reg_addr, EPC_A_LOAD, reg_wr)) load_q <= reg_wdata[0];
			if (wr_hit(reg_addr, EPC_A_PRE_LO, reg_wr)) pre_lo_q <= reg_wdata;
			if (wr_hit(reg_addr, EPC_A_PRE_HI, reg_wr)) pre_hi_q <= reg_wdata;
			if (wr_hit(reg_addr, EPC_A_DIVISOR, reg_wr)) divisor_q <= reg_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Encoder decode: one count per rising edge of A, so quadrature runs at x1
	logic a_q;
	logic b_q;
	logic a_prev_q;
	logic [31:0] count_q;
	logic [31:0] count_d;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			a_q      <= 1'b0;
			b_q      <= 1'b0;
			a_prev_q <= 1'b0;
		end else begin
			a_q      <= enc_a;
			b_q      <= enc_b;
			a_prev_q <= a_q;
		end
	end

	// Direction: quadrature forward when B is low at the A rise, held between rises,
	// since the B level of a shaft at rest says nothing; pulse-dir uses the B level
	logic pulse;
	logic raw_fwd;
	logic quad_fwd;
	logic qdir_q;
	logic single;
	assign pulse    = a_q && !a_prev_q;
	assign single   = (kind_q == EPC_KIND_SINGLE);
	assign quad_fwd = pulse ? !b_q : qdir_q;
	assign raw_fwd  = (kind_q == EPC_KIND_PDIR) ? b_q : quad_fwd;
	assign dir_fwd  = single ? 1'b1 : (raw_fwd ^ invert_q);
	assign ppr_out  = ppr_q;

	// Last quadrature direction; forward out of reset
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) qdir_q <= 1'b1;
		else qdir_q <= quad_fwd;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Counter; single-pulse with auto direction counts up since no direction exists
	logic step;
	logic go_up;
	logic at_max;
	logic at_min;
	logic [31:0] preset;
	assign preset = {pre_hi_q, pre_lo_q};
	assign step   = enable_q && pulse;
	assign go_up  = (dirsel_q == EPC_DIR_UP) ? 1'b1 :
			(dirsel_q == EPC_DIR_DOWN) ? 1'b0 : dir_fwd;
	assign at_max = (count_q == EPC_CNT_MAX);
	assign at_min = (count_q == EPC_CNT_MIN);

	// Load first, then a step that wraps or saturates at the ends
	always_comb begin
		count_d = count_q;
		if (load_q) begin
			count_d = preset;
		end else if (step && go_up) begin
			if (!at_max) count_d = count_q + 32'h0000_0001;
			else if (wrap_q) count_d = EPC_CNT_MIN;
			else count_d = EPC_CNT_MAX;
		end else if (step) begin
			if (!at_min) count_d = count_q - 32'h0000_0001;
			else if (wrap_q) count_d = EPC_CNT_MAX;
			else count_d = EPC_CNT_MIN;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) count_q <= EPC_CNT_MIN;
		else count_q <= count_d;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Restoring divider, restarted after each result; 34 cycles per update
	epc_div_st_t st_q;
	logic [31:0] num_q;
	logic [31:0] den_q;
	logic [31:0] quo_q;
	logic [32:0] rem_q;
	logic [5:0]  cnt_q;
	logic [32:0] rem_sh;
	logic        fits;
	logic [15:0] den_safe;
	assign den_safe = (divisor_q == 16'h0000) ? 16'h0001 : divisor_q; // Zero would give an all-ones quotient
	assign rem_sh   = {rem_q[31:0], quo_q[31]};
	assign fits     = (rem_sh >= {1'b0, den_q});
	assign dest_wr  = (st_q == EPC_DIV_DONE);
	assign dest_tag = tag_q;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q       <= EPC_DIV_IDLE;
			num_q      <= 32'h0000_0000;
			den_q      <= 32'h0000_0001;
			quo_q      <= 32'h0000_0000;
			rem_q      <= 33'h0_0000_0000;
			cnt_q      <= 6'h00;
			dest_value <= 32'h0000_0000;
		end else begin
			case (st_q)
				EPC_DIV_IDLE: begin
					num_q <= count_q;
					quo_q <= count_q;
					den_q <= {16'h0000, den_safe};
					rem_q <= 33'h0_0000_0000;
					cnt_q <= 6'h00;
					st_q  <= EPC_DIV_RUN;
				end
				EPC_DIV_RUN: begin
					rem_q <= fits ? (rem_sh - {1'b0, den_q}) : rem_sh;
					quo_q <= {quo_q[30:0], fits};
					cnt_q <= cnt_q + 6'h01;
					if (cnt_q == EPC_DIV_STEPS - 6'h01) st_q <= EPC_DIV_DONE;
				end
				EPC_DIV_DONE: begin
					dest_value <= quo_q;
					st_q       <= EPC_DIV_IDLE;
				end
				default: st_q <= EPC_DIV_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read mux; data valid only in the cycle after the strobe
	logic [15:0] rd_mux;
	always_comb begin
		if (reg_addr == EPC_A_KIND) rd_mux = {14'h0000, kind_q};
		else if (reg_addr == EPC_A_PPR) rd_mux = ppr_q;
		else if (reg_addr == EPC_A_INVERT) rd_mux = {15'h0000, invert_q};
		else if (reg_addr == EPC_A_TAG) rd_mux = tag_q;
		else if (reg_addr == EPC_A_ENABLE) rd_mux = {15'h0000, enable_q};
		else if (reg_addr == EPC_A_DIRSEL) rd_mux = {14'h0000, dirsel_q};
		else if (reg_addr == EPC_A_WRAP) rd_mux = {15'h0000, wrap_q};
		else if (reg_addr == EPC_A_LOAD) rd_mux = {15'h0000, load_q};
		else if (reg_addr == EPC_A_PRE_LO) rd_mux = pre_lo_q;
		else if (reg_addr == EPC_A_PRE_HI) rd_mux = pre_hi_q;
		else if (reg_addr == EPC_A_VAL_LO) rd_mux = count_q[EPC_HALF_LO +: 16];
		else if (reg_addr == EPC_A_VAL_HI) rd_mux = count_q[EPC_HALF_HI +: 16];
		else if (reg_addr == EPC_A_DIVISOR) rd_mux = divisor_q;
		else if (reg_addr == EPC_A_STATUS) rd_mux = {14'h0000, dest_wr, dir_fwd};
		else rd_mux = 16'h0000;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) reg_rdata <= 16'h0000;
		else reg_rdata <= reg_rd ? rd_mux : 16'h0000;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	property p_load_prio;
		load_q |=> count_q == $past(preset);
	endproperty
	a_load_prio: assert property (p_load_prio) else $error("preset not loaded");

	property p_disabled_hold;
		!load_q && !enable_q |=> count_q == $past(count_q);
	endproperty
	a_disabled_hold: assert property (p_disabled_hold) else $error("count moved");

	property p_up_inc;
		!load_q && step && dirsel_q == EPC_DIR_UP && !at_max |=> count_q == $past(count_q) + 1;
	endproperty
	a_up_inc: assert property (p_up_inc) else $error("up step wrong");

	property p_down_dec;
		!load_q && step && dirsel_q == EPC_DIR_DOWN && !at_min |=> count_q == $past(count_q) - 1;
	endproperty
	a_down_dec: assert property (p_down_dec) else $error("down step wrong");

	property p_auto_follow;
		!load_q && step && dirsel_q == EPC_DIR_AUTO && !dir_fwd && !at_min
			|=> count_q == $past(count_q) - 1;
	endproperty
	a_auto_follow: assert property (p_auto_follow) else $error("auto dir wrong");

	property p_wrap_up;
		!load_q && step && go_up && at_max && wrap_q |=> count_q == EPC_CNT_MIN;
	endproperty
	a_wrap_up: assert property (p_wrap_up) else $error("no wrap at max");

	property p_sat_down;
		!load_q && step && !go_up && at_min && !wrap_q |=> count_q == EPC_CNT_MIN;
	endproperty
	a_sat_down: assert property (p_sat_down) else $error("no hold at min");

	property p_sat_up;
		!load_q && step && go_up && at_max && !wrap_q |=> count_q == EPC_CNT_MAX;
	endproperty
	a_sat_up: assert property (p_sat_up) else $error("no hold at max");

	property p_wrap_down;
		!load_q && step && !go_up && at_min && wrap_q |=> count_q == EPC_CNT_MAX;
	endproperty
	a_wrap_down: assert property (p_wrap_down) else $error("no wrap at min");

	property p_pdir_level;
		kind_q == EPC_KIND_PDIR |-> dir_fwd == (b_q ^ invert_q);
	endproperty
	a_pdir_level: assert property (p_pdir_level) else $error("pulse dir wrong");

	property p_single_nodir;
		single |-> dir_fwd;
	endproperty
	a_single_nodir: assert property (p_single_nodir) else $error("single has dir");

	property p_read_lo;
		reg_rd && reg_addr == EPC_A_VAL_LO |=> reg_rdata == $past(count_q[15:0]);
	endproperty
	a_read_lo: assert property (p_read_lo) else $error("low half read wrong");

	property p_div_result;
		st_q == EPC_DIV_IDLE |-> ##33 dest_wr ##1 dest_value == num_q / den_q;
	endproperty
	a_div_result: assert property (p_div_result) else $error("divide wrong");

	c_wrap:  cover property (step && at_max && wrap_q && go_up);
	c_load:  cover property (load_q && step);
	c_write: cover property (dest_wr && tag_q != EPC_RST_TAG);

endmodule // epc_top

// [verif/epc_enc_model.sv]
`timescale 1ns/10ps
// Stand-in for the motor-mounted encoder; phases change just after a clock edge
module epc_enc_model
	import epc_pkg::*;
(
	input  wire logic core_clk, // System clock
	output logic      enc_a,    // Channel A
	output logic      enc_b     // Channel B
);
	// Encoder at rest with both channels low
	initial begin
		enc_a = 1'b0;
		enc_b = 1'b0;
	end

	////////////////////////////////////////////////////////////
	// One phase, held gap cycles; a gap of one is the fastest legal rotation
	task automatic ph(input logic a, input logic b, input int gap);
		@(posedge core_clk);
		enc_a <= a;
		enc_b <= b;
		repeat (gap - 1) @(posedge core_clk);
	endtask

	// Four phases per pulse, packed as {A,B} pairs, first phase in the top bits
	task automatic spin(input logic [1:0] kind, input logic fwd, input int n, input int gap);
		logic [7:0] seq;
		if (kind == EPC_KIND_PDIR) begin
			seq = {1'b0, fwd, 1'b1, fwd, 1'b0, fwd, 1'b0, fwd};
		end else if (kind == EPC_KIND_SINGLE) begin
			seq = 8'h91; // B keeps moving so any use of it shows
		end else if (fwd) begin
			seq = 8'hb4; // A leads B
		end else begin
			seq = 8'h78; // B leads A
		end
		for (int i = 0; i < n; i++) begin
			for (int j = 0; j < 4; j++) begin
				ph(seq[7 - 2 * j], seq[6 - 2 * j], gap);
			end
		end
	endtask
endmodule // epc_enc_model

// [verif/test_epc_top.sv]
`timescale 1ns/10ps
// Self-checking bench for the encoder pulse counter
module test_epc_top;
	import epc_pkg::*;
	typedef struct packed {
		logic [1:0]  kind;
		logic        inv;
		logic [1:0]  dsel;
		logic        en;
		logic        fwd;
		logic [3:0]  n;
		logic [31:0] exp;
	} epc_row_t;
	logic        core_clk;
	logic        rst_b;
	logic [3:0]  reg_addr;
	logic [15:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [15:0] reg_rdata;
	logic        enc_a;
	logic        enc_b;
	logic [15:0] ppr_out;
	logic        dir_fwd;
	logic [15:0] dest_tag;
	logic [31:0] dest_value;
	logic        dest_wr;
	logic [15:0] v16;
	logic [31:0] v32;
	int          n_fail = 0;
	int          tests_run = 0;
	// Start from 0x0001_0000 so a step down borrows across the halves
	epc_row_t rows [9] = '{
		'{EPC_KIND_QUAD, 1'b0, EPC_DIR_AUTO, 1'b1, 1'b1, 4'h3, 32'h0001_0003},
		'{EPC_KIND_QUAD, 1'b0, EPC_DIR_AUTO, 1'b1, 1'b0, 4'h2, 32'h0000_fffe},
		'{EPC_KIND_QUAD, 1'b1, EPC_DIR_AUTO, 1'b1, 1'b1, 4'h2, 32'h0000_fffe},
		'{EPC_KIND_PDIR, 1'b0, EPC_DIR_AUTO, 1'b1, 1'b1, 4'h2, 32'h0001_0002},
		'{EPC_KIND_PDIR, 1'b1, EPC_DIR_AUTO, 1'b1, 1'b1, 4'h1, 32'h0000_ffff},
		'{EPC_KIND_SINGLE, 1'b1, EPC_DIR_AUTO, 1'b1, 1'b0, 4'h2, 32'h0001_0002},
		'{EPC_KIND_QUAD, 1'b0, EPC_DIR_UP, 1'b1, 1'b0, 4'h2, 32'h0001_0002},
		'{EPC_KIND_QUAD, 1'b0, EPC_DIR_DOWN, 1'b1, 1'b1, 4'h2, 32'h0000_fffe},
		'{EPC_KIND_QUAD, 1'b0, EPC_DIR_AUTO, 1'b0, 1'b1, 4'h3, 32'h0001_0000}};
	logic [3:0]  rst_a [12] = '{EPC_A_KIND, EPC_A_PPR, EPC_A_INVERT, EPC_A_TAG, EPC_A_ENABLE,
		EPC_A_DIRSEL, EPC_A_WRAP, EPC_A_LOAD, EPC_A_PRE_LO, EPC_A_PRE_HI, EPC_A_DIVISOR, 4'he};
	logic [15:0] rst_e [12] = '{16'h0, 16'h0400, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0,
		16'h0, 16'h0, 16'h0001, 16'h0};

	epc_top i_epc_top (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.enc_a(enc_a), .enc_b(enc_b), .ppr_out(ppr_out), .dir_fwd(dir_fwd),
		.dest_tag(dest_tag), .dest_value(dest_value), .dest_wr(dest_wr));
	epc_enc_model i_epc_enc_model (.core_clk(core_clk), .enc_a(enc_a), .enc_b(enc_b));

	////////////////////////////////////////////////////////////
	// 125 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	// Compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Bus cycles; a gap cycle between strobes keeps each strobe a clean pulse
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr    <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd   <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	task automatic rd32(output logic [31:0] v);
		logic [15:0] lo;
		logic [15:0] hi;
		rd(EPC_A_VAL_LO, lo);
		rd(EPC_A_VAL_HI, hi);
		v = {hi, lo};
	endtask

	// Load a preset by pulsing the load control
	task automatic pre(input logic [31:0] p);
		wr(EPC_A_PRE_LO, p[15:0]);
		wr(EPC_A_PRE_HI, p[31:16]);
		wr(EPC_A_LOAD, 16'h0001);
		wr(EPC_A_LOAD, 16'h0000);
	endtask

	// Bounded wait for the destination write, then step past it
	task automatic wait_dest();
		int k;
		for (k = 0; k < 80 && dest_wr !== 1'b1; k++) begin
			@(posedge core_clk);
			#1;
		end
		@(posedge core_clk);
		#1;
	endtask

	task automatic spin_chk(input logic fwd, input int n, input logic [31:0] exp);
		i_epc_enc_model.spin(EPC_KIND_QUAD, fwd, n, 1);
		repeat (4) @(posedge core_clk);
		rd32(v32);
		chk(v32, exp);
	endtask

	task automatic complete_run();
		if (n_fail == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////
	// Main sequence: reset values, table rows, then boundary cases
	initial begin
		rst_b     = 1'b0;
		reg_addr  = 4'h0;
		reg_wdata = 16'h0;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		repeat (10) @(posedge core_clk);
		rst_b <= 1'b1;
		wr(4'he, 16'hffff);
		foreach (rst_a[i]) begin
			rd(rst_a[i], v16);
			chk(v16, rst_e[i]);
		end
		chk(ppr_out, 16'h0400);
		chk(dest_tag, 16'h0000);
		wr(EPC_A_PPR, 16'h0800);
		wr(EPC_A_TAG, 16'h0a05);
		#1;
		chk(ppr_out, 16'h0800);
		chk(dest_tag, 16'h0a05);
		foreach (rows[i]) begin
			wr(EPC_A_KIND, {14'h0, rows[i].kind});
			wr(EPC_A_INVERT, {15'h0, rows[i].inv});
			wr(EPC_A_DIRSEL, {14'h0, rows[i].dsel});
			wr(EPC_A_ENABLE, {15'h0, rows[i].en});
			pre(32'h0001_0000);
			i_epc_enc_model.spin(rows[i].kind, rows[i].fwd, rows[i].n, 1 + i % 3);
			repeat (4) @(posedge core_clk);
			rd32(v32);
			chk(v32, rows[i].exp);
			chk(dir_fwd, (rows[i].kind == EPC_KIND_SINGLE) | (rows[i].fwd ^ rows[i].inv));
		end
		// Limits, in both directions, with and without rollover
		wr(EPC_A_ENABLE, 16'h0001);
		wr(EPC_A_DIRSEL, {14'h0, EPC_DIR_UP});
		pre(32'hffff_fffe);
		spin_chk(1'b1, 3, 32'hffff_ffff);
		wr(EPC_A_WRAP, 16'h0001);
		spin_chk(1'b1, 1, 32'h0000_0000);
		wr(EPC_A_DIRSEL, {14'h0, EPC_DIR_DOWN});
		spin_chk(1'b1, 1, 32'hffff_ffff);
		wr(EPC_A_WRAP, 16'h0000);
		pre(32'h0000_0001);
		spin_chk(1'b1, 3, 32'h0000_0000);
		// Held load beats pulses
		wr(EPC_A_PRE_LO, 16'h1234);
		wr(EPC_A_PRE_HI, 16'h0005);
		wr(EPC_A_LOAD, 16'h0001);
		spin_chk(1'b1, 2, 32'h0005_1234);
		wr(EPC_A_LOAD, 16'h0000);
		// Low count half ignores writes
		wr(EPC_A_VAL_LO, 16'h5555);
		rd(EPC_A_VAL_LO, v16);
		chk(v16, 16'h1234);
		// Destination gets floor(100 / 7)
		wr(EPC_A_ENABLE, 16'h0000);
		pre(32'h0000_0064);
		wr(EPC_A_DIVISOR, 16'h0007);
		wait_dest();
		wait_dest();
		chk(dest_value, 32'h0000_000e);
		// Reset in mid-run brings back the defaults and clears the count
		@(posedge core_clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk(dest_value, 32'h0000_0000);
		rst_b <= 1'b1;
		#1;
		chk(ppr_out, 16'h0400);
		chk(dest_tag, 16'h0000);
		rd32(v32);
		chk(v32, 32'h0000_0000);
		rd(EPC_A_STATUS, v16);
		chk(v16, 16'h0001);
		complete_run();
	end

	// Watchdog far beyond the few hundred cycles the sequence needs
	initial begin
		#(8 * 20000);
		n_fail++;
		complete_run();
	end
endmodule // test_epc_top
